// >>> design/lsg_defines.svh
// Purpose: offsets, field positions, reset values and widths of the light sensor parameter block
// Assumes: included by bare name
// Notes: offsets are register indices; the byte address is four times the index
`ifndef LSG_DEFINES_SVH
`define LSG_DEFINES_SVH

`define LSG_IDX_VIS_GAIN        6'h11
`define LSG_IDX_VISIBLE_HIGH_RANGE_SELECT       6'h12
`define LSG_IDX_PROX_HYST       6'h17
`define LSG_IDX_AMB_HYST        6'h16
`define LSG_IDX_PROX_COUNT      6'h18
`define LSG_IDX_AMB_COUNT       6'h19
`define LSG_IDX_STATUS          6'h20

`define LSG_GAIN_MSB            2
`define LSG_GAIN_LSB            0
`define LSG_RANGE_BIT           5
`define LSG_GAIN_MASK           8'h07
`define LSG_RANGE_MASK          8'h20

`define LSG_RST_VIS_GAIN        8'h00
`define LSG_RST_VISIBLE_HIGH_RANGE_SELECT       8'h00
`define LSG_RST_HYST            8'h48
`define LSG_RST_COUNT           8'h03
`define LSG_RST_HYST_COUNT      16'h0018

`define LSG_STAT_AMB_UPPER      0
`define LSG_STAT_AMB_LOWER      1
`define LSG_STAT_PROX1          2
`define LSG_STAT_PROX2          3
`define LSG_STAT_PROX3          4
`define LSG_NUM_CMP             5

`define LSG_FRAC_BITS           4
`define LSG_DIV_W               7

`endif

// >>> design/lsg_pkg.sv
// Purpose: shared types of the light sensor parameter block
// Assumes: nothing
// Notes: constants live in lsg_defines.svh
package lsg_pkg;

  typedef logic [7:0]  lsg_code_t;
  typedef logic [15:0] lsg_count_t;
  typedef logic [2:0]  lsg_exp_t;

  typedef enum logic [1:0] {
    LSG_CH_PROX1 = 2'h0,
    LSG_CH_PROX2 = 2'h1,
    LSG_CH_PROX3 = 2'h2
  } lsg_prox_ch_e;

endpackage

// >>> design/lsg_expand.sv
// Purpose: expands an 8-bit compressed code into a 16-bit count
// Assumes: purely combinational; caller registers the result
// Notes: upper nibble is a power-of-two exponent, lower nibble sixteenths
`timescale 1ns/100ps
`default_nettype none
`include "lsg_defines.svh"

module lsg_expand
(
  input  wire lsg_pkg::lsg_code_t  code,
  output var lsg_pkg::lsg_count_t  count
);

  logic [19:0] scaled;

  // (16 + mant) << exp never exceeds 20 bits, so the shifted-down value fits 16 bits
  always_comb
  begin
    scaled = 20'({1'b1, code[3:0]}) << code[7:4];
    count  = scaled[19:`LSG_FRAC_BITS];
  end

endmodule
`default_nettype wire

// >>> design/lsg_params.sv
// Functional notes
// - integration time grows by 2^gain field
// - gain code seven gives factor 128
// - code four divides conversion clock by sixteen
// - range bit five selects high signal range
// - ambient hysteresis widens both ambient thresholds
// - proximity hysteresis widens all three thresholds
// - hysteresis stored compressed, expands to 16 bits
// - hysteresis codes reset to 0x48
// - gain and range reset to zero
// - early silicon applies visible settings to infrared
// - status changes after configured consecutive samples
//
// Purpose: parameter registers, conversion pacing and hysteresis threshold status
// Assumes: classic wishbone slave, 32-bit data, samples from logic on clk
// Notes: one ack per request, registered; unmapped indices ack and read zero
`timescale 1ns/100ps
`default_nettype none
`include "lsg_defines.svh"

module lsg_params
#(
  parameter bit EARLY_REVISION = 1'b0
)
(
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  ambient_sample_valid,
  input  wire lsg_pkg::lsg_count_t   ambient_sample,
  input  wire lsg_pkg::lsg_count_t   ambient_lower_threshold,
  input  wire lsg_pkg::lsg_count_t   ambient_upper_threshold,
  input  wire logic                  proximity_sample_valid,
  input  wire lsg_pkg::lsg_prox_ch_e proximity_channel,
  input  wire lsg_pkg::lsg_count_t   proximity_sample,
  input  wire lsg_pkg::lsg_count_t   proximity_channel1_threshold,
  input  wire lsg_pkg::lsg_count_t   proximity_channel2_threshold,
  input  wire lsg_pkg::lsg_count_t   proximity_channel3_threshold,
  output logic                       visible_conv_tick,
  output logic                       infrared_conv_tick,
  output logic                       visible_high_range_select,
  output logic                       infrared_high_range_select,
  output lsg_pkg::lsg_count_t        ambient_hysteresis_count,
  output lsg_pkg::lsg_count_t        proximity_hysteresis_count,
  output logic [`LSG_NUM_CMP-1:0]    threshold_status
);

  lsg_pkg::lsg_exp_t   visible_gain_exponent;
  logic                visible_high_range;
  lsg_pkg::lsg_code_t  ambient_hysteresis;
  lsg_pkg::lsg_code_t  proximity_hysteresis;
  lsg_pkg::lsg_code_t  ambient_consecutive_count;
  lsg_pkg::lsg_code_t  proximity_consecutive_count;

  lsg_pkg::lsg_count_t next_amb_hyst;
  lsg_pkg::lsg_count_t next_prox_hyst;

  logic [5:0]              idx;
  logic                    req;
  logic                    wr;
  logic [`LSG_DIV_W-1:0]   vis_div;
  logic [`LSG_DIV_W-1:0]   ir_div;
  lsg_pkg::lsg_exp_t       ir_exp;
  logic [7:0]              exceed_hist [`LSG_NUM_CMP];
  logic [7:0]              return_hist [`LSG_NUM_CMP];

  // terminal count of the conversion divider: 2^exp - 1, so code 7 gives 127, a 128-clock period
  function automatic logic [`LSG_DIV_W-1:0] div_last(input lsg_pkg::lsg_exp_t e);
    logic [`LSG_DIV_W:0] f;
    f = (`LSG_DIV_W+1)'(1) << e;
    div_last = `LSG_DIV_W'(f - (`LSG_DIV_W+1)'(1));
  endfunction

  // sample beyond threshold by more than the margin; 17 bits avoid wrap
  function automatic logic beyond(input lsg_pkg::lsg_count_t s,
                                  input lsg_pkg::lsg_count_t th,
                                  input lsg_pkg::lsg_count_t hy,
                                  input logic                above);
    logic [16:0] a;
    logic [16:0] b;
    a = above ? {1'b0, s} : ({1'b0, s} + {1'b0, hy});
    b = above ? ({1'b0, th} + {1'b0, hy}) : {1'b0, th};
    beyond = above ? (a > b) : (a < b);
  endfunction

  // history bit-field: every set bit must see a qualifying sample
  function automatic logic history_met(input logic [7:0] hist,
                                       input lsg_pkg::lsg_code_t mask);
    history_met = ((hist & mask) == mask);
  endfunction

  lsg_expand u_amb_expand
  (
    .code  (ambient_hysteresis),
    .count (next_amb_hyst)
  );

  lsg_expand u_prox_expand
  (
    .code  (proximity_hysteresis),
    .count (next_prox_hyst)
  );

  assign idx = wb_adr_i[7:2];
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr  = req && wb_we_i && wb_sel_i[0];

  // bus answer: one cycle after the request, dropped the cycle after
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= req;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else if (req && !wb_we_i)
    begin
      wb_dat_o <= 32'h0000_0000;
      unique case (idx)
        `LSG_IDX_VIS_GAIN:   wb_dat_o[7:0] <= {5'h00, visible_gain_exponent};
        `LSG_IDX_VISIBLE_HIGH_RANGE_SELECT:  wb_dat_o[7:0] <= {2'h0, visible_high_range, 5'h00};
        `LSG_IDX_AMB_HYST:   wb_dat_o[7:0] <= ambient_hysteresis;
        `LSG_IDX_PROX_HYST:  wb_dat_o[7:0] <= proximity_hysteresis;
        `LSG_IDX_AMB_COUNT:  wb_dat_o[7:0] <= ambient_consecutive_count;
        `LSG_IDX_PROX_COUNT: wb_dat_o[7:0] <= proximity_consecutive_count;
        `LSG_IDX_STATUS:     wb_dat_o[`LSG_NUM_CMP-1:0] <= threshold_status;
        default:             wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // gain and range registers; reserved bits are never stored
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      visible_gain_exponent <= 3'(`LSG_RST_VIS_GAIN);
      visible_high_range    <= 1'(`LSG_RST_VISIBLE_HIGH_RANGE_SELECT >> `LSG_RANGE_BIT);
    end
    else if (wr && idx == `LSG_IDX_VIS_GAIN)
    begin
      visible_gain_exponent <= wb_dat_i[`LSG_GAIN_MSB:`LSG_GAIN_LSB];
    end
    else if (wr && idx == `LSG_IDX_VISIBLE_HIGH_RANGE_SELECT)
    begin
      visible_high_range <= wb_dat_i[`LSG_RANGE_BIT];
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ambient_hysteresis   <= `LSG_RST_HYST;
      proximity_hysteresis <= `LSG_RST_HYST;
    end
    else if (wr && idx == `LSG_IDX_AMB_HYST)
    begin
      ambient_hysteresis <= wb_dat_i[7:0];
    end
    else if (wr && idx == `LSG_IDX_PROX_HYST)
    begin
      proximity_hysteresis <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ambient_consecutive_count   <= `LSG_RST_COUNT;
      proximity_consecutive_count <= `LSG_RST_COUNT;
    end
    else if (wr && idx == `LSG_IDX_AMB_COUNT)
    begin
      ambient_consecutive_count <= wb_dat_i[7:0];
    end
    else if (wr && idx == `LSG_IDX_PROX_COUNT)
    begin
      proximity_consecutive_count <= wb_dat_i[7:0];
    end
  end

  // expanded margins are registered so comparators see a stable value
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ambient_hysteresis_count   <= `LSG_RST_HYST_COUNT;
      proximity_hysteresis_count <= `LSG_RST_HYST_COUNT;
    end
    else
    begin
      ambient_hysteresis_count   <= next_amb_hyst;
      proximity_hysteresis_count <= next_prox_hyst;
    end
  end

  // infrared conversions follow the visible settings only on early silicon
  assign ir_exp = EARLY_REVISION ? visible_gain_exponent : 3'h0;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      visible_high_range_select  <= 1'b0;
      infrared_high_range_select <= 1'b0;
    end
    else
    begin
      visible_high_range_select  <= visible_high_range;
      infrared_high_range_select <= EARLY_REVISION && visible_high_range;
    end
  end

  // conversion clock divider: one tick every 2^gain clocks
  // a gain change takes effect at once; a partly counted period may be cut short
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      vis_div           <= '0;
      visible_conv_tick <= 1'b0;
    end
    else if (vis_div >= div_last(visible_gain_exponent))
    begin
      vis_div           <= '0;
      visible_conv_tick <= 1'b1;
    end
    else
    begin
      vis_div           <= vis_div + `LSG_DIV_W'(1);
      visible_conv_tick <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ir_div             <= '0;
      infrared_conv_tick <= 1'b0;
    end
    else if (ir_div >= div_last(ir_exp))
    begin
      ir_div             <= '0;
      infrared_conv_tick <= 1'b1;
    end
    else
    begin
      ir_div             <= ir_div + `LSG_DIV_W'(1);
      infrared_conv_tick <= 1'b0;
    end
  end

  // threshold status with hysteresis and consecutive-sample qualification
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      threshold_status <= '0;
      for (int i = 0; i < `LSG_NUM_CMP; i++)
      begin
        exceed_hist[i] <= 8'h00;
        return_hist[i] <= 8'h00;
      end
    end
    else
    begin
      for (int i = 0; i < `LSG_NUM_CMP; i++)
      begin
        logic                sel;
        logic                above;
        logic                exc;
        logic                ret;
        logic [7:0]          ne;
        logic [7:0]          nr;
        lsg_pkg::lsg_count_t s;
        lsg_pkg::lsg_count_t th;
        lsg_pkg::lsg_count_t hy;
        lsg_pkg::lsg_code_t  mask;
        sel   = 1'b0;
        above = (i != `LSG_STAT_AMB_LOWER);
        s     = proximity_sample;
        th    = proximity_channel1_threshold;
        hy    = proximity_hysteresis_count;
        mask  = proximity_consecutive_count;
        unique case (i)
          `LSG_STAT_AMB_UPPER:
          begin
            sel  = ambient_sample_valid;
            s    = ambient_sample;
            th   = ambient_upper_threshold;
            hy   = ambient_hysteresis_count;
            mask = ambient_consecutive_count;
          end
          `LSG_STAT_AMB_LOWER:
          begin
            sel  = ambient_sample_valid;
            s    = ambient_sample;
            th   = ambient_lower_threshold;
            hy   = ambient_hysteresis_count;
            mask = ambient_consecutive_count;
          end
          `LSG_STAT_PROX1:
          begin
            sel = proximity_sample_valid && proximity_channel == lsg_pkg::LSG_CH_PROX1;
            th  = proximity_channel1_threshold;
          end
          `LSG_STAT_PROX2:
          begin
            sel = proximity_sample_valid && proximity_channel == lsg_pkg::LSG_CH_PROX2;
            th  = proximity_channel2_threshold;
          end
          default:
          begin
            sel = proximity_sample_valid && proximity_channel == lsg_pkg::LSG_CH_PROX3;
            th  = proximity_channel3_threshold;
          end
        endcase
        exc = beyond(s, th, hy, above);
        ret = beyond(s, th, hy, !above);
        ne  = {exceed_hist[i][6:0], exc};
        nr  = {return_hist[i][6:0], ret};
        if (sel)
        begin
          exceed_hist[i] <= ne;
          return_hist[i] <= nr;
          if (history_met(ne, mask))
          begin
            threshold_status[i] <= 1'b1;
          end
          else if (history_met(nr, mask))
          begin
            threshold_status[i] <= 1'b0;
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

// >>> verification/lsg_params_chk.sv
// Purpose: port-level assertions on the light sensor parameter block
// Assumes: one clock, asynchronous active-low reset
// Notes: hysteresis expansion is recomputed here independently
`timescale 1ns/100ps
`default_nettype none
`include "lsg_defines.svh"

module lsg_params_chk
#(
  parameter bit EARLY_REVISION = 1'b0
)
(
  input wire logic                clk,
  input wire logic                resetn,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic [7:0]          wb_adr_i,
  input wire logic [3:0]          wb_sel_i,
  input wire logic [31:0]         wb_dat_i,
  input wire logic [31:0]         wb_dat_o,
  input wire logic                wb_ack_o,
  input wire logic                ambient_sample_valid,
  input wire logic                proximity_sample_valid,
  input wire logic                infrared_conv_tick,
  input wire logic                visible_high_range_select,
  input wire logic                infrared_high_range_select,
  input wire lsg_pkg::lsg_count_t ambient_hysteresis_count,
  input wire lsg_pkg::lsg_count_t proximity_hysteresis_count,
  input wire logic [4:0]          threshold_status
);
  logic take;
  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // 21 bits: mantissa 31 shifted by 15 needs 20
  function automatic logic [15:0] expand(input logic [31:0] c);
    logic [20:0] v;
    v = 21'(5'h10 + c[3:0]) << c[7:4];
    return v[19:4];
  endfunction

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  AST_ACK_NEXT: assert property (take |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_RSVD_ZERO: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  AST_GAIN_RSVD: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h11
    |-> wb_dat_o[7:3] == 5'h0) else $error("gain reserved bits not zero");
  AST_HYST_RESET: assert property ($rose(resetn) |-> ambient_hysteresis_count == 16'h0018
    && proximity_hysteresis_count == 16'h0018) else $error("hysteresis reset count wrong");
  AST_AMB_EXPAND: assert property (take && wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == 6'h16
    |-> ##2 ambient_hysteresis_count == expand($past(wb_dat_i, 2)))
    else $error("ambient hysteresis expansion wrong");
  AST_IR_RANGE: assert property (infrared_high_range_select
    == (EARLY_REVISION && visible_high_range_select)) else $error("infrared range select wrong");
  AST_IR_TICK: assert property (!EARLY_REVISION && $past(resetn) |-> infrared_conv_tick)
    else $error("infrared tick not free running");
  AST_STATUS_HOLD: assert property (!ambient_sample_valid && !proximity_sample_valid
    |=> $stable(threshold_status)) else $error("status moved without a sample");

  cover property (take && wb_we_i);
  cover property ($rose(threshold_status[0]));
  cover property ($rose(threshold_status[3]));
endmodule

bind lsg_params lsg_params_chk #(.EARLY_REVISION(EARLY_REVISION)) u_chk (.clk, .resetn,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .ambient_sample_valid, .proximity_sample_valid, .infrared_conv_tick,
  .visible_high_range_select, .infrared_high_range_select, .ambient_hysteresis_count,
  .proximity_hysteresis_count, .threshold_status);
`default_nettype wire

// >>> verification/lsg_host.sv
// Purpose: host model issuing classic wishbone single cycles
// Assumes: ack is registered by the slave
// Notes: samples ack before the edge lands, so no race with the slave
`timescale 1ns/100ps
`default_nettype none

module lsg_host
(
  input  wire logic        clk,
  input  wire logic        wb_ack_o,
  input  wire logic [31:0] wb_dat_o,
  output logic             wb_cyc_i,
  output logic             wb_stb_i,
  output logic             wb_we_i,
  output logic [7:0]       wb_adr_i,
  output logic [3:0]       wb_sel_i,
  output logic [31:0]      wb_dat_i
);
  initial
  begin
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
  end

  task automatic xfer(input logic w, input logic [5:0] i, input logic [7:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= {i, 2'b00};
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h0, d};
    do
      @(posedge clk);
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> verification/test_light_sensor_gain_hysteresis_params.sv
// Purpose: self-checking bench for the light sensor parameter block
// Assumes: host model drives the register bus
// Notes: outputs are judged at the falling edge, after updates land, except checks made right after a bus read
`timescale 1ns/100ps
`default_nettype none

module test_light_sensor_gain_hysteresis_params;
  logic                  clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]            wb_adr_i;
  logic [3:0]            wb_sel_i;
  logic [31:0]           wb_dat_i, wb_dat_o;
  logic                  ambient_sample_valid, proximity_sample_valid;
  logic                  visible_conv_tick, infrared_conv_tick;
  logic                  visible_high_range_select, infrared_high_range_select;
  lsg_pkg::lsg_count_t   ambient_sample, ambient_lower_threshold, ambient_upper_threshold;
  lsg_pkg::lsg_count_t   proximity_sample, proximity_channel1_threshold;
  lsg_pkg::lsg_count_t   proximity_channel2_threshold, proximity_channel3_threshold;
  lsg_pkg::lsg_count_t   ambient_hysteresis_count, proximity_hysteresis_count;
  lsg_pkg::lsg_prox_ch_e proximity_channel;
  logic [4:0]            threshold_status;
  int                    num_errors, checks_done;
  logic                  e_itick, e_irange;

  lsg_params DUT (.clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .ambient_sample_valid, .ambient_sample,
    .ambient_lower_threshold, .ambient_upper_threshold, .proximity_sample_valid,
    .proximity_channel, .proximity_sample, .proximity_channel1_threshold,
    .proximity_channel2_threshold, .proximity_channel3_threshold, .visible_conv_tick,
    .infrared_conv_tick, .visible_high_range_select, .infrared_high_range_select,
    .ambient_hysteresis_count, .proximity_hysteresis_count, .threshold_status);

  lsg_host u_host (.clk, .wb_ack_o, .wb_dat_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i);

  // early-silicon build sees the same bus and samples; only its infrared outputs are judged
  lsg_params #(.EARLY_REVISION(1'b1)) DUT_EARLY (.clk, .resetn, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o(), .wb_ack_o(),
    .ambient_sample_valid, .ambient_sample, .ambient_lower_threshold,
    .ambient_upper_threshold, .proximity_sample_valid, .proximity_channel,
    .proximity_sample, .proximity_channel1_threshold, .proximity_channel2_threshold,
    .proximity_channel3_threshold, .visible_conv_tick(), .infrared_conv_tick(e_itick),
    .visible_high_range_select(), .infrared_high_range_select(e_irange),
    .ambient_hysteresis_count(), .proximity_hysteresis_count(), .threshold_status());

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic [31:0] q;
    u_host.xfer(1'b1, i, d, q);
  endtask

  task automatic rd(input logic [5:0] i, input logic [7:0] e, input string n);
    logic [31:0] q;
    u_host.xfer(1'b0, i, 8'h00, q);
    cmp(n, {24'h0, e}, q);
  endtask

  task automatic samp(input logic p, input logic [15:0] v);
    @(posedge clk);
    ambient_sample <= v;
    proximity_sample <= v;
    ambient_sample_valid <= !p;
    proximity_sample_valid <= p;
    @(posedge clk);
    ambient_sample_valid <= 1'b0;
    proximity_sample_valid <= 1'b0;
  endtask

  task automatic t_reset;
    rd(6'h11, 8'h00, "gain");
    rd(6'h12, 8'h00, "range");
    rd(6'h16, 8'h48, "amb_hyst");
    rd(6'h17, 8'h48, "prox_hyst");
    cmp("amb_cnt", 32'h18, {16'h0, ambient_hysteresis_count});
  endtask

  task automatic t_regs;
    wr(6'h11, 8'hFF);
    rd(6'h11, 8'h07, "gain_rsvd");
    wr(6'h12, 8'hFF);
    rd(6'h12, 8'h20, "range_rsvd");
    cmp("visible_high_range_select", 32'h1, {31'h0, visible_high_range_select});
    cmp("ir_range", 32'h0, {31'h0, infrared_high_range_select});
    cmp("ir_range_early", 32'h1, {31'h0, e_irange});
    rd(6'h13, 8'h00, "unmapped");
    wr(6'h12, 8'h00);
    @(negedge clk);
    cmp("vis_norm", 32'h0, {31'h0, visible_high_range_select});
  endtask

  // measures a whole period: the first tick after a gain change may be short
  task automatic t_tick(input logic [2:0] g);
    int n;
    wr(6'h11, {5'h0, g});
    @(negedge clk);
    while (visible_conv_tick !== 1'b1)
      @(negedge clk);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (visible_conv_tick !== 1'b1 && n < 300);
    cmp("tick_period", 32'h1 << g, n);
    cmp("ir_tick_early", 32'h1, {31'h0, e_itick});
  endtask

  task automatic t_hyst;
    wr(6'h16, 8'h27);
    wr(6'h17, 8'hFF);
    @(negedge clk);
    cmp("amb_cnt", 32'h5, {16'h0, ambient_hysteresis_count});
    cmp("prox_cnt", 32'hF800, {16'h0, proximity_hysteresis_count});
    rd(6'h16, 8'h27, "amb_rd");
    wr(6'h16, 8'h48);
    wr(6'h17, 8'h48);
    @(negedge clk);
    cmp("amb_24", 32'h18, {16'h0, ambient_hysteresis_count});
    cmp("prox_24", 32'h18, {16'h0, proximity_hysteresis_count});
  endtask

  task automatic t_thr;
    @(posedge clk);
    ambient_upper_threshold <= 16'h64;
    ambient_lower_threshold <= 16'h64;
    proximity_channel1_threshold <= 16'hFFFF;
    proximity_channel2_threshold <= 16'h64;
    proximity_channel3_threshold <= 16'hFFFF;
    proximity_channel <= lsg_pkg::LSG_CH_PROX2;
    samp(1'b0, 16'h7C);
    samp(1'b0, 16'h7D);
    @(negedge clk);
    cmp("edge_one", 32'h0, {27'h0, threshold_status});
    samp(1'b0, 16'h7D);
    @(negedge clk);
    cmp("upper", 32'h1, {27'h0, threshold_status});
    samp(1'b0, 16'h4B);
    samp(1'b0, 16'h4B);
    @(negedge clk);
    cmp("lower", 32'h2, {27'h0, threshold_status});
    samp(1'b1, 16'h7D);
    samp(1'b1, 16'h7D);
    @(negedge clk);
    cmp("prox", 32'hA, {27'h0, threshold_status});
    rd(6'h20, 8'h0A, "stat_rd");
    wr(6'h19, 8'h07);
    // no-channel code must not touch channel two, which two low samples would clear
    proximity_channel <= lsg_pkg::lsg_prox_ch_e'(2'h3);
    samp(1'b1, 16'h0);
    samp(1'b1, 16'h0);
    samp(1'b0, 16'h7D);
    samp(1'b0, 16'h7D);
    @(negedge clk);
    cmp("two_of_three", 32'hA, {27'h0, threshold_status});
    samp(1'b0, 16'h7D);
    @(negedge clk);
    cmp("three_of_three", 32'h9, {27'h0, threshold_status});
    rd(6'h19, 8'h07, "amb_count_rd");
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim;
  end

  initial
  begin
    resetn = 1'b0;
    ambient_sample_valid = 1'b0;
    proximity_sample_valid = 1'b0;
    ambient_sample = 16'h0;
    proximity_sample = 16'h0;
    ambient_lower_threshold = 16'h0;
    ambient_upper_threshold = 16'hFFFF;
    proximity_channel1_threshold = 16'hFFFF;
    proximity_channel2_threshold = 16'hFFFF;
    proximity_channel3_threshold = 16'hFFFF;
    proximity_channel = lsg_pkg::LSG_CH_PROX1;
    num_errors = 0;
    checks_done = 0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    t_reset;
    t_regs;
    t_tick(3'h0);
    t_tick(3'h4);
    t_tick(3'h6);
    t_tick(3'h7);
    t_hyst;
    t_thr;
    end_sim;
  end
endmodule
`default_nettype wire
